// [eetc_cfg.svh]
// constants of the external edge trigger capture block
`ifndef EETC_CFG_SVH
`define EETC_CFG_SVH
`define EETC_NCH            6
`define EETC_CLK_HZ         20000000
`define EETC_MS_CYC         ((`EETC_CLK_HZ + 999) / 1000)
`define EETC_GAP_MS_DEF     16'h0064
`define EETC_EDGE_FALL      2'h0
`define EETC_EDGE_RISE      2'h1
`define EETC_EDGE_BOTH      2'h2
`define EETC_PULL_NONE      2'h0
`define EETC_PULL_UP        2'h1
`define EETC_PULL_DOWN      2'h2
`define EETC_SER_MASK       6'h03
`define EETC_SPI_MASK       6'h3c
`define EETC_I2C_MASK       6'h1c
`endif

// [eetc_pkg.sv]
// types of the external edge trigger capture block
`default_nettype none
package eetc_pkg;
  typedef enum logic [1:0] {EETC_IDLE, EETC_HOLD} eetc_chst_t;
endpackage
`default_nettype wire

// [eetc_chan.sv]
// one trigger channel: synchroniser, edge detect, hold-off
`default_nettype none
`include "eetc_cfg.svh"
module eetc_chan
  import eetc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        pin_in,
  input  wire logic        enable,
  input  wire logic [1:0]  edge_sel,
  input  wire logic [15:0] gap_ms,
  output logic             level,
  output logic             fire
);
  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       prev;
    eetc_chst_t st;
    logic [15:0] cnt;
    logic [14:0] sub;
  } eetc_cs_t;
  eetc_cs_t q_r;
  eetc_cs_t q_nxt;
  logic     rise;
  logic     fall;
  logic     hit;

  always_comb
  begin
    q_nxt = q_r;
    q_nxt.s1 = pin_in;
    q_nxt.s2 = q_r.s1;                                   // RULE20
    q_nxt.prev = q_r.s2;
    rise = q_r.s2 & ~q_r.prev;
    fall = ~q_r.s2 & q_r.prev;
    case (edge_sel)                                      // RULE9
      `EETC_EDGE_FALL: hit = fall;
      `EETC_EDGE_RISE: hit = rise;
      `EETC_EDGE_BOTH: hit = rise | fall;
      default:         hit = 1'b0;
    endcase
    fire = 1'b0;
    case (q_r.st)
      EETC_IDLE:
      begin
        if (enable && hit)
        begin
          fire = 1'b1;
          q_nxt.st = EETC_HOLD;                          // RULE17
          q_nxt.cnt = gap_ms;
          q_nxt.sub = 15'h0000;
        end
      end
      EETC_HOLD:
      begin
        // own ms count: a shared free-running tick would cut the first ms short
        if (!enable || q_r.cnt == 16'h0000)
          q_nxt.st = EETC_IDLE;
        else if (q_r.sub == 15'(`EETC_MS_CYC - 1))
        begin
          q_nxt.sub = 15'h0000;
          q_nxt.cnt = q_r.cnt - 16'h0001;                // RULE17
        end
        else
          q_nxt.sub = q_r.sub + 15'h0001;
      end
      default: q_nxt.st = EETC_IDLE;
    endcase
    level = q_r.s2;                                      // RULE8
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      q_r <= '{s1: 1'b0, s2: 1'b0, prev: 1'b0, st: EETC_IDLE, cnt: 16'h0000,
               sub: 15'h0000};
    else
      q_r <= q_nxt;
  end

  // a qualifying edge while idle fires once
  property p_fire_cause;
    @(posedge clk) disable iff (sys_rst)
      fire |-> enable && q_r.st == EETC_IDLE && (q_r.s2 != q_r.prev);
  endproperty
  a_fire_cause: assert property (p_fire_cause) else $error("fire without edge"); // RULE9

  property p_holdoff;
    @(posedge clk) disable iff (sys_rst)
      fire |=> !fire;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("fire repeated"); // RULE17
endmodule // eetc_chan
`default_nettype wire

// [eetc_top.sv]
// external edge trigger capture: six channels, timestamps, pin sharing
//
// Summary of operation
// RULE1: each of six shared pins can be put in edge-trigger mode on its own.
// RULE2: an enabled pin seeing its chosen edge pulses that channel's interrupt.
// RULE3: each activation captures calendar time and epoch seconds plus milliseconds.
// RULE4: each activation sets the channel activation flag to one.
// RULE5: enabling a trigger disables the serial, SPI or I2C port on that pin.
// RULE6: enabling serial, SPI or I2C disables triggers on the shared pins; the logic skips this in a cycle with a valid cfg_wr.
// RULE7: rate setting, disable-all or unit reset restore serial on channels 1-2.
// RULE8: live pin level is readable any time, apart from the activation flag.
// RULE9: edge choice is falling, rising, or both for any change.
// RULE10: pull choice is none, up or down, roughly 40K each.
// RULE11: with no pull the outside party must drive valid levels.
// RULE12: one channel or all channels can be disabled, back to normal pins.
// RULE13: configuration and status readable for all channels or a selected one.
// RULE14: wake inhibit stops a channel's activation waking the unit.
// RULE15: software configures one channel per request, index 1 to 6.
// RULE16: trigger reset clears all channel state and starts new logs; the logic clears only the activation flags.
// RULE17: a per-channel millisecond hold-off limits activations, default 100 ms.
// RULE18: wake on activation is on unless wake inhibit is chosen.
// RULE19: activation flag reads one after activation, zero otherwise.
// RULE20: each pin passes two flip-flops before edge detection.
// RULE21: flag clears on read or reconfigure; timestamp holds until next event.
`default_nettype none
`include "eetc_cfg.svh"
module eetc_top
  import eetc_pkg::*;
#(
  parameter int NCH = `EETC_NCH
)(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [NCH-1:0]    trig_pin,
  // configuration request, one channel each
  input  wire logic              cfg_wr,
  input  wire logic [2:0]        cfg_chan,
  input  wire logic              cfg_enable,
  input  wire logic [1:0]        cfg_edge,
  input  wire logic [1:0]        cfg_pull,
  input  wire logic [15:0]       cfg_gap_ms,
  input  wire logic              cfg_gap_given,
  input  wire logic              cfg_wake_inhibit,
  input  wire logic              disable_all,
  input  wire logic              trigger_reset,
  input  wire logic              serial_rate_setting,
  input  wire logic              serial_enable_req,
  input  wire logic              spi_enable_req,
  input  wire logic              i2c_enable_req,
  input  wire logic              flag_rd,
  input  wire logic [2:0]        rd_chan,
  input  wire logic [31:0]       now_calendar,
  input  wire logic [31:0]       now_epoch_s,
  input  wire logic [9:0]        now_ms,
  output logic [NCH-1:0]         trig_irq,
  output logic                   wake_req,
  output logic                   log_restart,
  output logic [NCH-1:0]         pin_live_level,
  output logic [NCH-1:0]         activation_flag,
  output logic [NCH-1:0]         trig_enabled,
  output logic [NCH-1:0]         pull_up_en,
  output logic [NCH-1:0]         pull_down_en,
  output logic                   serial_on,
  output logic                   spi_on,
  output logic                   i2c_on,
  output logic [1:0]             rd_edge,
  output logic [1:0]             rd_pull,
  output logic [15:0]            rd_gap_ms,
  output logic                   rd_wake_inhibit,
  output logic [31:0]            last_event_calendar_time,
  output logic [31:0]            last_event_epoch_time,
  output logic [9:0]             last_event_epoch_ms
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [NCH-1:0]       en;
    logic [NCH-1:0][1:0]  edge_m;
    logic [NCH-1:0][1:0]  pull;
    logic [NCH-1:0][15:0] gap;
    logic [NCH-1:0]       wake_inhibit;
    logic [NCH-1:0]       flag;
    logic [NCH-1:0][31:0] cal;
    logic [NCH-1:0][31:0] ep;
    logic [NCH-1:0][9:0]  ms;
    logic [NCH-1:0][31:0] cal_o;
    logic [31:0]          ep_o;
    logic [9:0]           ms_o;
    logic                 ser;
    logic                 spi;
    logic                 i2c;
    logic                 logr;
  } eetc_st_t;
  eetc_st_t s_r;
  eetc_st_t s_nxt;

  logic [NCH-1:0] fire;
  logic [NCH-1:0] lvl;

  // one-hot channel select from a 1-based index; out of range selects none
  function automatic logic [NCH-1:0] eetc_sel(input logic [2:0] idx);
    logic [NCH-1:0] m;
    m = '0;
    for (int i = 0; i < NCH; i++)
      if (idx == 3'(i + 1))
        m[i] = 1'b1;
    return m;
  endfunction

  function automatic logic [2:0] eetc_idx(input logic [2:0] c);
    return (c >= 3'h1 && c <= 3'(NCH)) ? (c - 3'h1) : 3'h0;
  endfunction


  ////////////////////////////////////////////////////////////////////////////
  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    eetc_chan u_ch (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .pin_in   (trig_pin[g]),
      .enable   (s_r.en[g]),
      .edge_sel (s_r.edge_m[g]),
      .gap_ms   (s_r.gap[g]),
      .level    (lvl[g]),
      .fire     (fire[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic [NCH-1:0] sel;
    logic [NCH-1:0] rsel;
    logic [NCH-1:0] port_off;
    sel = eetc_sel(cfg_chan);                            // RULE15
    rsel = eetc_sel(rd_chan);
    port_off = '0;
    s_nxt = s_r;
    s_nxt.logr = 1'b0;
    // peripheral requests take the pins back in cycles without a valid cfg_wr
    if (serial_enable_req || serial_rate_setting)
      port_off = port_off | `EETC_SER_MASK;              // RULE6
    if (spi_enable_req)
      port_off = port_off | `EETC_SPI_MASK;
    if (i2c_enable_req)
      port_off = port_off | `EETC_I2C_MASK;
    if (serial_enable_req || serial_rate_setting)
      s_nxt.ser = 1'b1;                                  // RULE7
    if (spi_enable_req)
      s_nxt.spi = 1'b1;
    if (i2c_enable_req)
      s_nxt.i2c = 1'b1;
    s_nxt.en = s_r.en & ~port_off;
    if (cfg_wr && sel != '0)
    begin
      s_nxt.en = (s_r.en & ~sel) | (cfg_enable ? sel : '0); // RULE1 RULE12
      s_nxt.flag = s_r.flag & ~sel;                      // RULE21
      for (int i = 0; i < NCH; i++)
        if (sel[i])
        begin
          s_nxt.edge_m[i] = cfg_edge;
          s_nxt.pull[i] = cfg_pull;                      // RULE10
          s_nxt.gap[i] = cfg_gap_given ? cfg_gap_ms : `EETC_GAP_MS_DEF; // RULE17
          s_nxt.wake_inhibit[i] = cfg_wake_inhibit;            // RULE18
        end
      if (cfg_enable)
      begin
        if ((sel & `EETC_SER_MASK) != '0)
          s_nxt.ser = 1'b0;                              // RULE5
        if ((sel & `EETC_SPI_MASK) != '0)
          s_nxt.spi = 1'b0;
        if ((sel & `EETC_I2C_MASK) != '0)
          s_nxt.i2c = 1'b0;
      end
    end
    if (disable_all)
    begin
      s_nxt.en = '0;                                     // RULE12
      s_nxt.ser = 1'b1;                                  // RULE7
    end
    if (flag_rd)
      s_nxt.flag = s_nxt.flag & ~rsel;                   // RULE21
    if (trigger_reset)
    begin
      s_nxt.flag = '0;                                   // RULE16
      s_nxt.logr = 1'b1;
    end
    // set beats clear
    for (int i = 0; i < NCH; i++)
      if (fire[i])
      begin
        s_nxt.flag[i] = 1'b1;                            // RULE4
        s_nxt.cal[i] = now_calendar;                     // RULE3
        s_nxt.ep[i] = now_epoch_s;
        s_nxt.ms[i] = now_ms;
      end
    s_nxt.cal_o = s_nxt.cal;
    s_nxt.ep_o = s_nxt.ep[eetc_idx(rd_chan)];            // RULE13
    s_nxt.ms_o = s_nxt.ms[eetc_idx(rd_chan)];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_r <= '0;
      s_r.ser <= 1'b1;                                   // RULE7
    end
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign trig_irq = fire;                                // RULE2
  assign wake_req = |(fire & ~s_r.wake_inhibit);               // RULE14
  assign log_restart = s_r.logr;
  assign pin_live_level = lvl;                           // RULE8
  assign activation_flag = s_r.flag;                     // RULE19
  assign trig_enabled = s_r.en;
  assign serial_on = s_r.ser;
  assign spi_on = s_r.spi;
  assign i2c_on = s_r.i2c;
  assign rd_edge = s_r.edge_m[eetc_idx(rd_chan)];        // RULE13
  assign rd_pull = s_r.pull[eetc_idx(rd_chan)];
  assign rd_gap_ms = s_r.gap[eetc_idx(rd_chan)];
  assign rd_wake_inhibit = s_r.wake_inhibit[eetc_idx(rd_chan)];
  assign last_event_calendar_time = s_r.cal_o[eetc_idx(rd_chan)];
  assign last_event_epoch_time = s_r.ep_o;
  assign last_event_epoch_ms = s_r.ms_o;
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      pull_up_en[i] = s_r.en[i] && s_r.pull[i] == `EETC_PULL_UP;
      pull_down_en[i] = s_r.en[i] && s_r.pull[i] == `EETC_PULL_DOWN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_flag_set;
    @(posedge clk) disable iff (sys_rst)
      (|fire) |=> (activation_flag & $past(fire)) == $past(fire);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set"); // RULE4

  property p_stamp;
    @(posedge clk) disable iff (sys_rst)
      fire[0] |=> s_r.ep[0] == $past(now_epoch_s) && s_r.cal[0] == $past(now_calendar);
  endproperty
  a_stamp: assert property (p_stamp) else $error("timestamp not captured"); // RULE3

  property p_port_off;
    @(posedge clk) disable iff (sys_rst)
      cfg_wr && cfg_enable && cfg_chan == 3'h3 && !spi_enable_req && !disable_all
      |=> !spi_on && !i2c_on;
  endproperty
  a_port_off: assert property (p_port_off) else $error("port not released"); // RULE5

  property p_trig_off;
    @(posedge clk) disable iff (sys_rst)
      spi_enable_req |=> (trig_enabled & `EETC_SPI_MASK) == '0;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("trigger kept on spi pin"); // RULE6

  property p_ser_back;
    @(posedge clk) disable iff (sys_rst)
      (disable_all || serial_rate_setting) |=> serial_on;
  endproperty
  a_ser_back: assert property (p_ser_back) else $error("serial not restored"); // RULE7

  property p_all_off;
    @(posedge clk) disable iff (sys_rst)
      disable_all |=> trig_enabled == '0;
  endproperty
  a_all_off: assert property (p_all_off) else $error("triggers left on"); // RULE12

  property p_wake;
    @(posedge clk) disable iff (sys_rst)
      wake_req |-> (|(fire & ~s_r.wake_inhibit));
  endproperty
  a_wake: assert property (p_wake) else $error("wake without enabled channel"); // RULE14

  property p_reset_flags;
    @(posedge clk) disable iff (sys_rst)
      trigger_reset && fire == '0 |=> activation_flag == '0 && log_restart;
  endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("trigger reset failed"); // RULE16
endmodule // eetc_top
`default_nettype wire

// [eetc_pin_model.sv]
// behavioural model of the external signals on the six trigger pins
`default_nettype none
module eetc_pin_model
(
  input  wire logic       clk,
  input  wire logic [5:0] drive_en,
  input  wire logic [5:0] drive_val,
  input  wire logic [5:0] pull_up_en,
  input  wire logic [5:0] pull_down_en,
  output logic      [5:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] last_r;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
    last_r <= pin;
  // a floating pin wanders every cycle, so unpulled pins must be driven
  always_comb
    for (int i = 0; i < 6; i++)
      if (drive_en[i])
        pin[i] = drive_val[i];
      else if (pull_up_en[i] | pull_down_en[i])
        pin[i] = pull_up_en[i];
      else
        pin[i] = ~last_r[i];
endmodule // eetc_pin_model
`default_nettype wire

// [tb_top.sv]
// self-checking bench of the external edge trigger capture block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, sys_rst, cfg_wr, cfg_enable, cfg_gap_given, cfg_wake_inhibit;
  logic        wake_req, log_restart, serial_on, spi_on, i2c_on, rd_wake_inhibit;
  logic [2:0]  cfg_chan, rd_chan;
  logic [1:0]  cfg_edge, cfg_pull, rd_edge, rd_pull;
  logic [15:0] cfg_gap_ms, rd_gap_ms;
  logic [6:0]  ctl;
  logic [31:0] now_calendar, now_epoch_s, last_event_calendar_time, last_event_epoch_time;
  logic [9:0]  now_ms, last_event_epoch_ms;
  logic [5:0]  trig_pin, drv_en, drv_val, trig_irq, pin_live_level, activation_flag;
  logic [5:0]  trig_enabled, pull_up_en, pull_down_en, m;
  logic [6:0]  expq[$];
  int          mismatches, n_compared;
  ////////////////////////////////////////////////////////////////////////////
  eetc_top #(.NCH(6)) uut (.clk, .sys_rst, .trig_pin, .cfg_wr, .cfg_chan, .cfg_enable,
    .cfg_edge, .cfg_pull, .cfg_gap_ms, .cfg_gap_given, .cfg_wake_inhibit,
    .disable_all(ctl[0]), .trigger_reset(ctl[1]), .serial_rate_setting(ctl[2]),
    .serial_enable_req(ctl[3]), .spi_enable_req(ctl[4]), .i2c_enable_req(ctl[5]),
    .flag_rd(ctl[6]), .rd_chan, .now_calendar, .now_epoch_s, .now_ms, .trig_irq,
    .wake_req, .log_restart, .pin_live_level, .activation_flag, .trig_enabled,
    .pull_up_en, .pull_down_en, .serial_on, .spi_on, .i2c_on, .rd_edge, .rd_pull,
    .rd_gap_ms, .rd_wake_inhibit, .last_event_calendar_time, .last_event_epoch_time,
    .last_event_epoch_ms);
  eetc_pin_model pm (.clk, .drive_en(drv_en), .drive_val(drv_val), .pull_up_en,
    .pull_down_en, .pin(trig_pin));
  ////////////////////////////////////////////////////////////////////////////
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input logic [95:0] got, input logic [95:0] exp, input string msg);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask
  // one-cycle strobe, then room for the state to settle
  task pulse(input int k);
    @(posedge clk);
    ctl <= 7'h01 << k;
    @(posedge clk);
    ctl <= 7'h00;
    tick(3);
  endtask
  task cfg(input int c, input logic en, input logic [1:0] e, input logic [1:0] p,
           input logic [15:0] g, input logic wi);
    @(posedge clk);
    {cfg_wr, cfg_chan, cfg_enable, cfg_edge, cfg_pull, cfg_gap_ms, cfg_gap_given,
      cfg_wake_inhibit, rd_chan} <= {1'b1, c[2:0], en, e, p, g, g != 16'hffff, wi, c[2:0]};
    @(posedge clk);
    cfg_wr <= 1'b0;
    tick(3);
  endtask
  // note the activation before moving the pin; sync plus detect fit in 8 cycles
  task pin(input int c, input logic v, input logic hit, input logic wi);
    @(posedge clk);
    if (hit)
      expq.push_back({~wi, 6'h01 << (c - 1)});
    drv_val[c - 1] <= v;
    tick(8);
  endtask
  task end_sim();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // interrupts stand one cycle, so every cycle is inspected
  always @(posedge clk)
  begin
    #1;
    if (!sys_rst && (trig_irq !== 6'h00 || wake_req !== 1'b0))
      chk({wake_req, trig_irq}, expq.size() ? expq.pop_front() : 7'h7f, "irq");
  end
  initial
  begin
    #(60000 * 50);
    mismatches++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int c, e, wi;
    sys_rst = 1'b1;
    ctl = 7'h00;
    {cfg_wr, cfg_chan, cfg_enable, cfg_edge, cfg_pull, cfg_gap_ms, cfg_gap_given,
      cfg_wake_inhibit, rd_chan} = '0;
    {now_calendar, now_epoch_s, now_ms} = '0;
    drv_en = 6'h3f;
    drv_val = 6'h3f;
    void'($urandom(73875));
    tick(12);
    sys_rst <= 1'b0;
    tick(3);
    chk({serial_on, spi_on, i2c_on, trig_enabled, activation_flag}, 15'h4000, "reset");
    for (c = 1; c <= 6; c++)
      for (e = 0; e < 3; e++)
      begin
        m = 6'h01 << (c - 1);
        pin(c, e != 1, 1'b0, 1'b0);
        pulse(2);
        wi = $urandom % 2;
        @(posedge clk);
        {now_calendar, now_epoch_s, now_ms} <= {$urandom, $urandom, 10'($urandom % 1000)};
        cfg(c, 1'b1, e[1:0], e[1:0], 16'h0000, wi[0]);
        chk({c > 2, trig_enabled, pull_up_en, pull_down_en},
            {c > 2, m, (e == 1) ? m : 6'h00, (e == 2) ? m : 6'h00}, "enable");
        chk({rd_edge, rd_pull, rd_gap_ms, rd_wake_inhibit, pin_live_level[c - 1], serial_on},
            {e[1:0], e[1:0], 16'h0000, wi[0], e != 1, c < 3 ? 1'b0 : 1'b1}, "status");
        pin(c, e == 1, 1'b1, wi[0]);
        chk({activation_flag, last_event_calendar_time, last_event_epoch_time, last_event_epoch_ms},
            {m, now_calendar, now_epoch_s, now_ms}, "capture");
        pulse(6);
        chk(activation_flag, 6'h00, "flag read");
        pin(c, e != 1, e == 2, wi[0]);
        cfg(c, 1'b0, 2'h0, 2'h0, 16'h0000, 1'b0);
        chk(trig_enabled, 6'h00, "channel off");
      end
    $display("edge modes done");
    pin(2, 1'b0, 1'b0, 1'b0);
    cfg(2, 1'b1, 2'h2, 2'h0, 16'h0001, 1'b0);
    pin(2, 1'b1, 1'b1, 1'b0);
    pin(2, 1'b0, 1'b0, 1'b0);
    pin(2, 1'b1, 1'b0, 1'b0);
    tick(20100);
    pin(2, 1'b0, 1'b1, 1'b0);
    $display("hold-off done");
    @(posedge clk);
    ctl <= 7'h02;
    @(posedge clk);
    ctl <= 7'h00;
    e = 0;
    #1;
    while (log_restart !== 1'b1 && e < 4)
    begin
      @(posedge clk);
      #1;
      e++;
    end
    chk({log_restart, activation_flag}, 7'h40, "trigger reset");
    $display("trigger reset done");
    cfg(3, 1'b1, 2'h0, 2'h0, 16'h0000, 1'b0);
    cfg(1, 1'b1, 2'h0, 2'h0, 16'h0000, 1'b0);
    pulse(4);
    chk({spi_on, serial_on, trig_enabled}, 8'h83, "spi on");
    pulse(5);
    cfg(4, 1'b1, 2'h0, 2'h0, 16'h0000, 1'b0);
    chk({spi_on, i2c_on, trig_enabled}, 8'h0b, "trigger over spi");
    pulse(3);
    chk({serial_on, trig_enabled}, 7'h48, "serial on");
    pulse(0);
    chk({serial_on, trig_enabled}, 7'h40, "disable all");
    cfg(0, 1'b1, 2'h0, 2'h0, 16'h0000, 1'b0);
    cfg(7, 1'b1, 2'h0, 2'h0, 16'h0000, 1'b0);
    chk(trig_enabled, 6'h00, "bad index");
    // gap ffff in the task means no gap given, so the default applies
    cfg(1, 1'b1, 2'h0, 2'h0, 16'h0000, 1'b0);
    cfg(6, 1'b0, 2'h0, 2'h0, 16'hffff, 1'b0);
    chk({serial_on, trig_enabled, rd_gap_ms}, {1'b0, 6'h01, 16'h0064}, "default gap");
    @(posedge clk);
    sys_rst <= 1'b1;
    tick(2);
    sys_rst <= 1'b0;
    tick(3);
    chk({serial_on, trig_enabled}, 7'h40, "unit reset");
    $display("pin sharing done");
    pin(5, 1'b0, 1'b0, 1'b0);
    cfg(5, 1'b1, 2'h1, 2'h1, 16'h0000, 1'b0);
    @(posedge clk);
    expq.push_back(7'h50);
    drv_en <= 6'h2f;
    tick(8);
    chk(pin_live_level[4], 1'b1, "pull-up");
    chk(expq.size(), 0, "pending");
    $display("pull test done");
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
